/* i2c_host_model.sv */
// Behavioural I2C host driving the sensor register port
`timescale 1ns/1ns
module i2c_host_model import sense_ctrl_pkg::*; (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_h
);
	logic [6:0] ca = DEFAULT_CHIP_ADDR;
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// Quarter of a bit time
	task automatic hq();
		repeat (4) @(negedge clk);
	endtask : hq
	// Data changes only while the bus clock is low
	task automatic bitx(input logic b, output logic r);
		sda_h = b;
		hq();
		scl = 1'b1;
		hq();
		r = sda;
		hq();
		scl = 1'b0;
		hq();
	endtask : bitx
	// Byte sent MSB first, then the ninth bit
	task automatic bytex(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(a, ack);
	endtask : bytex
	task automatic start();
		sda_h = 1'b0;
		hq();
		scl = 1'b0;
		hq();
	endtask : start
	task automatic stop();
		sda_h = 1'b0;
		hq();
		scl = 1'b1;
		hq();
		sda_h = 1'b1;
		hq();
	endtask : stop
	// Pointer byte, then an optional data byte
	task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic hd, output logic ak);
		logic [7:0] q;
		logic a0;
		logic a1;
		logic a2;
		start();
		bytex({ca, 1'b0}, 1'b1, q, a0);
		bytex(p, 1'b1, q, a1);
		a2 = 1'b0;
		if (hd) begin
			bytex(d, 1'b1, q, a2);
		end
		stop();
		ak = a0 | a1 | a2;
	endtask : wr
	// One byte from the kept pointer, ended by a host NACK
	task automatic rd(output logic [7:0] q, output logic ak);
		logic [7:0] x;
		logic a1;
		start();
		bytex({ca, 1'b1}, 1'b1, x, ak);
		bytex(8'hff, 1'b1, q, a1);
		stop();
	endtask : rd
endmodule : i2c_host_model

/* i2c_reg_slave.sv */
// I2C slave with an auto-incrementing register pointer kept across transactions
`timescale 1ns/1ns
module i2c_reg_slave import sense_ctrl_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [6:0] chip_addr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic [7:0] reg_ptr,
	input wire logic [7:0] rd_data,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_REG = 3'b011,
		ST_WR = 3'b100,
		ST_RD = 3'b101,
		ST_RACK = 3'b110
	} i2c_state_e;

	typedef struct packed {
		i2c_state_e state;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic is_read;
		logic got_reg;
		logic sda_oe;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic scl_p;
		logic sda_p;
	} i2c_s;

	i2c_s cur_r;
	i2c_s cur_nxt;
	logic start_cond;
	logic stop_cond;
	logic scl_rise;
	logic scl_fall;

	// Bus conditions from the previous sample
	assign start_cond = scl_in && cur_r.scl_p && cur_r.sda_p && !sda_in;
	assign stop_cond = scl_in && cur_r.scl_p && !cur_r.sda_p && sda_in;
	assign scl_rise = scl_in && !cur_r.scl_p;
	assign scl_fall = !scl_in && cur_r.scl_p;

	// Byte engine
	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.scl_p = scl_in;
		cur_nxt.sda_p = sda_in;
		cur_nxt.wr_en = 1'b0;
		if (start_cond) begin
			cur_nxt.state = ST_ADDR;
			cur_nxt.bitcnt = 4'h0;
			cur_nxt.got_reg = 1'b0;
			cur_nxt.sda_oe = 1'b0;
		end else if (stop_cond) begin
			cur_nxt.state = ST_IDLE;
			cur_nxt.sda_oe = 1'b0;
		end else begin
			case (cur_r.state)
				ST_ADDR, ST_REG, ST_WR: begin
					if (scl_rise && cur_r.bitcnt != BITS_PER_BYTE) begin
						cur_nxt.shreg = {cur_r.shreg[6:0], sda_in};
						cur_nxt.bitcnt = cur_r.bitcnt + 4'h1;
					end else if (scl_fall && cur_r.bitcnt == BITS_PER_BYTE) begin
						cur_nxt.sda_oe = 1'b1;
						cur_nxt.state = ST_ACK;
						if (cur_r.state == ST_ADDR) begin
							cur_nxt.is_read = cur_r.shreg[0];
							if (cur_r.shreg[7:1] != chip_addr) begin
								cur_nxt.sda_oe = 1'b0;
								cur_nxt.state = ST_IDLE;
							end
						end else if (cur_r.state == ST_REG) begin
							cur_nxt.ptr = cur_r.shreg;
							cur_nxt.got_reg = 1'b1;
						end else begin
							cur_nxt.wr_en = 1'b1;
							cur_nxt.wr_addr = cur_r.ptr;
							cur_nxt.wr_data = cur_r.shreg;
							cur_nxt.ptr = cur_r.ptr + 8'h01; // RULE13
						end
					end
				end
				ST_ACK, ST_RACK: begin
					if (cur_r.state == ST_RACK && scl_rise && sda_in) begin
						cur_nxt.state = ST_IDLE; // Master ended the read
					end else if (scl_fall) begin
						cur_nxt.bitcnt = 4'h0;
						cur_nxt.sda_oe = 1'b0;
						if (cur_r.is_read) begin
							cur_nxt.state = ST_RD;
							cur_nxt.shreg = rd_data;
							cur_nxt.sda_oe = !rd_data[7];
						end else begin
							cur_nxt.state = cur_r.got_reg ? ST_WR : ST_REG;
						end
					end
				end
				ST_RD: begin
					if (scl_rise) begin
						cur_nxt.bitcnt = cur_r.bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (cur_r.bitcnt == BITS_PER_BYTE) begin
							cur_nxt.sda_oe = 1'b0;
							cur_nxt.ptr = cur_r.ptr + 8'h01; // RULE13
							cur_nxt.state = ST_RACK;
						end else begin
							cur_nxt.shreg = {cur_r.shreg[6:0], 1'b0};
							cur_nxt.sda_oe = !cur_r.shreg[6];
						end
					end
				end
				default: begin
					cur_nxt.state = ST_IDLE;
					cur_nxt.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// State register; pointer survives stop conditions
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_r <= '{state: ST_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = cur_r.sda_oe;
	assign reg_ptr = cur_r.ptr;
	assign wr_en = cur_r.wr_en;
	assign wr_addr = cur_r.wr_addr;
	assign wr_data = cur_r.wr_data;
endmodule : i2c_reg_slave

/* sense_ctrl.sv */
// Enable decoding, measurement timing and register file of the light and proximity sensor
//
// Contract
// [RULE1] Power-on bit starts the oscillator and powers the converter channels.
// [RULE2] Light-sense enable bit turns on ambient light and colour measurement.
// [RULE3] Proximity enable bit turns on proximity detection.
// [RULE4] Wait enable bit turns on the wait period between measurement cycles.
// [RULE5] Host writes zero into the four reserved upper enable bits.
// [RULE6] Host programs mode settings before setting light or proximity enable.
// [RULE7] Integration lasts integration register plus one, times 2.78 ms.
// [RULE8] Integration timer counts down from register value to terminal zero.
// [RULE9] Light result ceiling grows 1024 per step, saturating at 65535.
// [RULE10] Full scale reachable only with at least 64 integration steps.
// [RULE11] Proximity sample lasts register plus one times 88 us; resets to 0x1F.
// [RULE12] Wait lasts wait register plus one times 2.78 ms, twelvefold when long.
// [RULE13] I2C register pointer auto-increments per byte and survives transactions.
// [RULE14] With power-on cleared, no light, proximity or wait timing starts.
`timescale 1ns/1ns
module sense_ctrl import sense_ctrl_pkg::*; #(
	parameter int LIGHT_STEP_CYCLES_P = LIGHT_STEP_CYCLES,
	parameter int PROX_STEP_CYCLES_P = PROX_STEP_CYCLES,
	parameter logic [6:0] CHIP_ADDR = DEFAULT_CHIP_ADDR
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic osc_enable,
	output logic adc_power,
	output logic light_integrating,
	output logic prox_sampling,
	output logic wait_active,
	output logic light_done,
	output logic prox_done,
	output logic [15:0] light_max_value
);
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_LIGHT = 2'b01,
		SQ_PROX = 2'b10,
		SQ_WAIT = 2'b11
	} seq_state_e;

	typedef struct packed {
		logic [7:0] function_enable;
		logic [7:0] light_integration_time;
		logic [7:0] prox_sample_duration;
		logic [7:0] wait_period;
		logic [7:0] wait_config;
		seq_state_e seq;
		logic osc_enable;
		logic adc_power;
		logic light_start;
		logic prox_start;
		logic wait_start;
		logic light_done;
		logic prox_done;
		logic [16:0] light_acc;
		logic [15:0] light_max;
	} ctrl_s;

	ctrl_s cur_r;
	ctrl_s cur_nxt;

	// Internal reset copy
	logic [1:0] rst_sync_r;
	logic rst_n;

	// Register port handshake
	logic [7:0] reg_ptr;
	logic [7:0] rd_data;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	// Decoded enable fields
	logic power_on_bit;
	logic light_sense_enable;
	logic prox_enable;
	logic wait_enable;
	logic long_wait_select;

	// Timer status and strobes
	logic light_busy;
	logic light_step;
	logic light_end;
	logic prox_busy;
	logic prox_end;
	logic wait_busy;
	logic wait_end;
	logic [3:0] wait_repeat;
	logic [16:0] light_acc_add;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	// Synchronised copy resets every other flop
	assign rst_n = rst_sync_r[1];

	// Host register port
	i2c_reg_slave u_i2c (
		.clk(clk),
		.rst_n(rst_n),
		.chip_addr(CHIP_ADDR),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.reg_ptr(reg_ptr),
		.rd_data(rd_data),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	// Enable field decode
	assign power_on_bit = cur_r.function_enable[POWER_ON_BIT]; // RULE1
	assign light_sense_enable = cur_r.function_enable[LIGHT_SENSE_ENABLE_BIT]; // RULE2
	assign prox_enable = cur_r.function_enable[PROX_ENABLE_BIT]; // RULE3
	assign wait_enable = cur_r.function_enable[WAIT_ENABLE_BIT]; // RULE4

	// Long-wait mode stretches each wait step
	assign long_wait_select = cur_r.wait_config[LONG_WAIT_SELECT_BIT];
	assign wait_repeat = long_wait_select ? WAIT_LONG_REPEAT : WAIT_SHORT_REPEAT; // RULE12

	// Light integration timer, one step per 2.78 ms
	step_timer #(
		.STEP_CYCLES(LIGHT_STEP_CYCLES_P)
	) u_light_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(cur_r.light_start),
		.abort(!power_on_bit),
		.load(cur_r.light_integration_time),
		.repeat_cnt(WAIT_SHORT_REPEAT),
		.busy(light_busy),
		.step(light_step),
		.done(light_end)
	); // RULE7 RULE8

	// Proximity sample timer, one step per 88 us
	step_timer #(
		.STEP_CYCLES(PROX_STEP_CYCLES_P)
	) u_prox_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(cur_r.prox_start),
		.abort(!power_on_bit),
		.load(cur_r.prox_sample_duration),
		.repeat_cnt(WAIT_SHORT_REPEAT),
		.busy(prox_busy),
		.step(),
		.done(prox_end)
	); // RULE11

	// Wait timer, twelve base steps per count in long mode
	step_timer #(
		.STEP_CYCLES(LIGHT_STEP_CYCLES_P)
	) u_wait_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(cur_r.wait_start),
		.abort(!power_on_bit),
		.load(cur_r.wait_period),
		.repeat_cnt(wait_repeat),
		.busy(wait_busy),
		.step(),
		.done(wait_end)
	); // RULE12

	// Register read mux, unmapped offsets read zero
	always_comb begin
		case (reg_ptr)
			FUNCTION_ENABLE_ADDR: rd_data = cur_r.function_enable;
			LIGHT_INTEGRATION_TIME_ADDR: rd_data = cur_r.light_integration_time;
			PROX_SAMPLE_DURATION_ADDR: rd_data = cur_r.prox_sample_duration;
			WAIT_PERIOD_ADDR: rd_data = cur_r.wait_period;
			WAIT_CONFIG_ADDR: rd_data = cur_r.wait_config;
			// Status bits mirror the oscillator enable and live timer activity
			TIMING_STATUS_ADDR: begin
				rd_data = 8'h00;
				rd_data[STAT_OSC_BIT] = cur_r.osc_enable;
				rd_data[STAT_LIGHT_BIT] = light_busy;
				rd_data[STAT_PROX_BIT] = prox_busy;
				rd_data[STAT_WAIT_BIT] = wait_busy;
			end
			default: rd_data = 8'h00;
		endcase
	end

	// Next ceiling of the light result after one more step
	assign light_acc_add = cur_r.light_acc + LIGHT_COUNTS_PER_STEP;

	// Register writes, sequencing and light ceiling
	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.light_start = 1'b0;
		cur_nxt.prox_start = 1'b0;
		cur_nxt.wait_start = 1'b0;
		cur_nxt.light_done = light_end;
		cur_nxt.prox_done = prox_end;
		// Host writes; reserved enable bits are dropped
		if (wr_en) begin
			case (wr_addr)
				FUNCTION_ENABLE_ADDR: cur_nxt.function_enable = wr_data & FUNCTION_ENABLE_MASK; // RULE5
				LIGHT_INTEGRATION_TIME_ADDR: cur_nxt.light_integration_time = wr_data;
				PROX_SAMPLE_DURATION_ADDR: cur_nxt.prox_sample_duration = wr_data;
				WAIT_PERIOD_ADDR: cur_nxt.wait_period = wr_data;
				WAIT_CONFIG_ADDR: cur_nxt.wait_config = wr_data;
				default: cur_nxt.wait_config = cur_r.wait_config;
			endcase
		end
		// Oscillator and converters follow the power-on bit
		cur_nxt.osc_enable = power_on_bit; // RULE1
		cur_nxt.adc_power = power_on_bit; // RULE1
		// Sequencer: light, then proximity, then wait
		if (!power_on_bit) begin
			cur_nxt.seq = SQ_IDLE; // RULE14
		end else begin
			case (cur_r.seq)
				SQ_IDLE: begin
					// Wait alone never starts a cycle
					if (light_sense_enable) begin
						cur_nxt.light_start = 1'b1; // RULE2
						cur_nxt.light_acc = 17'h00000;
						cur_nxt.light_max = 16'h0000;
						cur_nxt.seq = SQ_LIGHT;
					end else if (prox_enable) begin
						cur_nxt.prox_start = 1'b1; // RULE3
						cur_nxt.seq = SQ_PROX;
					end
				end
				SQ_LIGHT: begin
					if (light_step) begin
						// Each completed step lifts the ceiling by 1024, up to full scale
						cur_nxt.light_acc = (light_acc_add > LIGHT_FULL_SCALE) ? LIGHT_FULL_SCALE + 17'h00001
							: light_acc_add; // RULE9
						cur_nxt.light_max = (light_acc_add > LIGHT_FULL_SCALE) ? LIGHT_FULL_SCALE[15:0]
							: 16'(light_acc_add - 17'h00001); // RULE10
					end
					if (light_end) begin
						if (prox_enable) begin
							cur_nxt.prox_start = 1'b1; // RULE3
							cur_nxt.seq = SQ_PROX;
						end else if (wait_enable) begin
							cur_nxt.wait_start = 1'b1; // RULE4
							cur_nxt.seq = SQ_WAIT;
						end else begin
							cur_nxt.seq = SQ_IDLE;
						end
					end
				end
				SQ_PROX: begin
					if (prox_end) begin
						if (wait_enable) begin
							cur_nxt.wait_start = 1'b1; // RULE4
							cur_nxt.seq = SQ_WAIT;
						end else begin
							cur_nxt.seq = SQ_IDLE;
						end
					end
				end
				SQ_WAIT: begin
					if (wait_end) begin
						cur_nxt.seq = SQ_IDLE;
					end
				end
				default: cur_nxt.seq = SQ_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_r <= '{function_enable: FUNCTION_ENABLE_RESET,
				light_integration_time: LIGHT_INTEGRATION_TIME_RESET,
				prox_sample_duration: PROX_SAMPLE_DURATION_RESET, // RULE11
				wait_period: WAIT_PERIOD_RESET,
				wait_config: WAIT_CONFIG_RESET,
				seq: SQ_IDLE,
				default: '0};
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// Outputs from flip-flops
	assign osc_enable = cur_r.osc_enable;
	assign adc_power = cur_r.adc_power;
	assign light_integrating = light_busy;
	assign prox_sampling = prox_busy;
	assign wait_active = wait_busy;
	assign light_done = cur_r.light_done;
	assign prox_done = cur_r.prox_done;
	assign light_max_value = cur_r.light_max;
endmodule : sense_ctrl

/* sense_ctrl_monitor.sv */
// Concurrent checks on the sensor control core ports
`timescale 1ns/1ns
module sense_ctrl_monitor import sense_ctrl_pkg::*; #(
	parameter int LIGHT_STEP_CYCLES_P = LIGHT_STEP_CYCLES,
	parameter int PROX_STEP_CYCLES_P = PROX_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic osc_enable,
	input wire logic adc_power,
	input wire logic light_integrating,
	input wire logic prox_sampling,
	input wire logic wait_active,
	input wire logic light_done,
	input wire logic prox_done,
	input wire logic [15:0] light_max_value
);
	int lcnt_r;
	int pcnt_r;
	int wcnt_r;
	// Length of the current high run of each timer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lcnt_r <= 0;
			pcnt_r <= 0;
			wcnt_r <= 0;
		end else begin
			lcnt_r <= light_integrating ? lcnt_r + 1 : 0;
			pcnt_r <= prox_sampling ? pcnt_r + 1 : 0;
			wcnt_r <= wait_active ? wcnt_r + 1 : 0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_osc_adc_tie: assert property (osc_enable == adc_power)
		else $error("oscillator and converter power differ");
	a_light_needs_on: assert property ($rose(light_integrating) |-> osc_enable)
		else $error("light timing started while powered off");
	a_prox_needs_on: assert property ($rose(prox_sampling) |-> osc_enable)
		else $error("proximity timing started while powered off");
	a_done_one_cycle: assert property (light_done |=> !light_done)
		else $error("light done longer than one cycle");
	a_done_follows_end: assert property (light_done |-> $past(light_integrating) || $past(light_integrating, 2))
		else $error("light done without an ending integration");
	a_prox_done_follows: assert property (prox_done |-> $past(prox_sampling) || $past(prox_sampling, 2))
		else $error("proximity done without an ending sample");
	a_max_at_done: assert property (light_done |-> light_max_value[9:0] == 10'h3ff)
		else $error("light ceiling not a whole step count");
	a_max_zero_start: assert property ($rose(light_integrating) |=> light_max_value == 16'h0000)
		else $error("light ceiling not cleared at start");
	a_light_step_len: assert property ($fell(light_integrating) && osc_enable |-> lcnt_r > 0 && lcnt_r % LIGHT_STEP_CYCLES_P == 0)
		else $error("integration not whole steps");
	a_prox_step_len: assert property ($fell(prox_sampling) && osc_enable |-> pcnt_r > 0 && pcnt_r % PROX_STEP_CYCLES_P == 0)
		else $error("proximity sample not whole steps");
	a_wait_step_len: assert property ($fell(wait_active) && osc_enable |-> wcnt_r > 0 && wcnt_r % LIGHT_STEP_CYCLES_P == 0)
		else $error("wait not whole steps");
	c_light_done: cover property (light_done);
	c_prox_done: cover property (prox_done);
	c_wait_end: cover property ($fell(wait_active));
endmodule : sense_ctrl_monitor
bind sense_ctrl sense_ctrl_monitor #(
	.LIGHT_STEP_CYCLES_P(LIGHT_STEP_CYCLES_P),
	.PROX_STEP_CYCLES_P(PROX_STEP_CYCLES_P)
) sense_ctrl_monitor_inst (.clk(clk), .reset_n(reset_n), .osc_enable(osc_enable), .adc_power(adc_power),
	.light_integrating(light_integrating), .prox_sampling(prox_sampling), .wait_active(wait_active),
	.light_done(light_done), .prox_done(prox_done), .light_max_value(light_max_value));

/* sense_ctrl_pkg.sv */
// Register map, field positions, reset values and timing constants of the sensor control core
package sense_ctrl_pkg;

	// Register offsets
	localparam logic [7:0] FUNCTION_ENABLE_ADDR = 8'h80;
	localparam logic [7:0] LIGHT_INTEGRATION_TIME_ADDR = 8'h81;
	localparam logic [7:0] PROX_SAMPLE_DURATION_ADDR = 8'h82;
	localparam logic [7:0] WAIT_PERIOD_ADDR = 8'h83;
	localparam logic [7:0] WAIT_CONFIG_ADDR = 8'h8d;
	localparam logic [7:0] TIMING_STATUS_ADDR = 8'ha8;

	// Reset values
	localparam logic [7:0] FUNCTION_ENABLE_RESET = 8'h00;
	localparam logic [7:0] LIGHT_INTEGRATION_TIME_RESET = 8'h00;
	localparam logic [7:0] PROX_SAMPLE_DURATION_RESET = 8'h1f;
	localparam logic [7:0] WAIT_PERIOD_RESET = 8'h00;
	localparam logic [7:0] WAIT_CONFIG_RESET = 8'h00;

	// Function enable fields
	localparam int POWER_ON_BIT = 0;
	localparam int LIGHT_SENSE_ENABLE_BIT = 1;
	localparam int PROX_ENABLE_BIT = 2;
	localparam int WAIT_ENABLE_BIT = 3;
	localparam logic [7:0] FUNCTION_ENABLE_MASK = 8'h0f;

	// Wait configuration field
	localparam int LONG_WAIT_SELECT_BIT = 2;

	// Timing status fields
	localparam int STAT_OSC_BIT = 0;
	localparam int STAT_LIGHT_BIT = 1;
	localparam int STAT_PROX_BIT = 2;
	localparam int STAT_WAIT_BIT = 3;

	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int LIGHT_STEP_NS = 2780000;
	localparam int PROX_STEP_NS = 88000;
	localparam int LIGHT_STEP_CYCLES = LIGHT_STEP_NS / CLK_PERIOD_NS;
	localparam int PROX_STEP_CYCLES = PROX_STEP_NS / CLK_PERIOD_NS;
	localparam logic [3:0] WAIT_SHORT_REPEAT = 4'h1;
	localparam logic [3:0] WAIT_LONG_REPEAT = 4'hc;

	// Light result ceiling
	localparam logic [16:0] LIGHT_COUNTS_PER_STEP = 17'h00400;
	localparam logic [16:0] LIGHT_FULL_SCALE = 17'h0ffff;

	// I2C slave
	localparam logic [6:0] DEFAULT_CHIP_ADDR = 7'h49;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : sense_ctrl_pkg

/* sense_ctrl_tb.sv */
// Self-checking bench for the sensor control core
`timescale 1ns/1ns
module sense_ctrl_tb import sense_ctrl_pkg::*;;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic scl;
	logic sda_h;
	logic sda;
	logic sda_out;
	logic sda_oe;
	logic osc_enable;
	logic adc_power;
	logic light_integrating;
	logic prox_sampling;
	logic wait_active;
	logic light_done;
	logic prox_done;
	logic [15:0] light_max_value;
	logic ak;
	logic [7:0] q;
	int err_total = 0;
	int tests_run = 0;
	int li_n = 0, pr_n = 0, wt_n = 0, li_len = 0, pr_len = 0, wt_len = 0;
	logic [15:0] mx = 16'h0000;
	logic [7:0] ra[6] = '{8'h81, 8'h82, 8'h83, 8'h80, 8'h90, 8'h8d};
	logic [7:0] wd[6] = '{8'h5a, 8'ha5, 8'h3c, 8'h08, 8'h77, 8'h04};
	logic [7:0] ex[6] = '{8'h5a, 8'ha5, 8'h3c, 8'h08, 8'h00, 8'h04};
	logic [7:0] rv[3] = '{8'h00, 8'h00, 8'h1f};
	// Open-drain data line with pull-up
	assign sda = sda_h & (~sda_oe | sda_out);
	initial begin
		forever #10 clk = ~clk;
	end
	sense_ctrl #(.LIGHT_STEP_CYCLES_P(4), .PROX_STEP_CYCLES_P(3)) sense_ctrl_inst (.clk(clk), .reset_n(reset_n),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .osc_enable(osc_enable),
		.adc_power(adc_power), .light_integrating(light_integrating), .prox_sampling(prox_sampling),
		.wait_active(wait_active), .light_done(light_done), .prox_done(prox_done),
		.light_max_value(light_max_value));
	i2c_host_model i2c_host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_h(sda_h));
	// Timer run lengths and light ceiling at done
	always @(posedge clk) begin
		li_n <= light_integrating ? li_n + 1 : 0;
		pr_n <= prox_sampling ? pr_n + 1 : 0;
		wt_n <= wait_active ? wt_n + 1 : 0;
		if (!light_integrating && li_n != 0) li_len <= li_n;
		if (!prox_sampling && pr_n != 0) pr_len <= pr_n;
		if (!wait_active && wt_n != 0) wt_len <= wt_n;
		if (light_done) mx <= light_max_value;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		i2c_host_model_inst.wr(a, d, 1'b1, ak);
		chk("write ack", ak, 0);
	endtask : wreg
	task automatic rdreg(input logic [7:0] a, output logic [7:0] v);
		logic a2;
		i2c_host_model_inst.wr(a, 8'h00, 1'b0, ak);
		i2c_host_model_inst.rd(v, a2);
		chk("read ack", {ak, a2}, 0);
	endtask : rdreg
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	initial begin
		// About twice the expected run length
		repeat (40000) @(posedge clk);
		err_total++;
		end_sim();
	end
	initial begin
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 3; i++) begin
			rdreg(8'(8'h80 + i), q);
			chk("reset value", q, rv[i]);
		end
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			wreg(ra[i], wd[i]);
			rdreg(ra[i], q);
			chk("register row", q, ex[i]);
		end
		$display("test register rows done");
		// Pointer advances per byte and survives the stop
		i2c_host_model_inst.wr(8'h81, 8'h00, 1'b0, ak);
		i2c_host_model_inst.rd(q, ak);
		chk("pointer first", q, 8'h5a);
		i2c_host_model_inst.rd(q, ak);
		chk("pointer kept", q, 8'ha5);
		$display("test pointer done");
		// Settings first, enables last; long wait
		wreg(8'h81, 8'h02);
		wreg(8'h82, 8'h01);
		wreg(8'h83, 8'h00);
		wreg(8'h8d, 8'h04);
		wreg(8'h80, 8'h0f);
		@(negedge wait_active);
		repeat (2) @(negedge clk);
		chk("osc on", {osc_enable, adc_power}, 2'b11);
		chk("light len", li_len, 12);
		chk("prox len", pr_len, 6);
		chk("long wait len", wt_len, 48);
		chk("light ceiling", mx, 16'h0bff);
		wreg(8'h80, 8'h00);
		wreg(8'h8d, 8'h00);
		wreg(8'h80, 8'h0f);
		@(negedge wait_active);
		@(negedge wait_active);
		repeat (2) @(negedge clk);
		chk("short wait len", wt_len, 4);
		$display("test timing done");
		wreg(8'h80, 8'h00);
		wreg(8'h81, 8'h3f);
		wreg(8'h80, 8'h03);
		@(posedge light_done);
		repeat (2) @(negedge clk);
		chk("full scale len", li_len, 256);
		chk("full scale", mx, 16'hffff);
		rdreg(8'ha8, q);
		chk("status running", q & 8'hfd, 8'h01);
		wreg(8'h80, 8'h00);
		wreg(8'h80, 8'h05);
		@(posedge prox_done);
		@(negedge clk);
		chk("prox only", {prox_done, light_integrating}, 2'b10);
		chk("prox only len", pr_len, 6);
		$display("test full scale done");
		wreg(8'h80, 8'h0e);
		repeat (100) @(negedge clk);
		chk("powered off", {osc_enable, adc_power, light_integrating, prox_sampling, wait_active}, 0);
		rdreg(8'ha8, q);
		chk("status off", q, 8'h00);
		$display("test power off done");
		// Foreign chip address is not acknowledged
		i2c_host_model_inst.ca = 7'h22;
		i2c_host_model_inst.wr(8'h81, 8'h99, 1'b1, ak);
		chk("foreign nack", ak, 1);
		i2c_host_model_inst.ca = DEFAULT_CHIP_ADDR;
		rdreg(8'h81, q);
		chk("foreign ignored", q, 8'h3f);
		// Second reset in mid-run
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		rdreg(8'h82, q);
		chk("reset again", q, 8'h1f);
		$display("test faults done");
		end_sim();
	end
endmodule : sense_ctrl_tb

/* step_timer.sv */
// Stepped down counter: prescaled step, optional step repeat, terminal count of zero
`timescale 1ns/1ns
module step_timer import sense_ctrl_pkg::*; #(
	parameter int STEP_CYCLES = LIGHT_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [7:0] load,
	input wire logic [3:0] repeat_cnt,
	output logic busy,
	output logic step,
	output logic done
);
	localparam int PW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
	localparam logic [PW-1:0] PRESC_TOP = PW'(STEP_CYCLES - 1);

	typedef struct packed {
		logic busy;
		logic step;
		logic done;
		logic [7:0] count;
		logic [3:0] rep_top;
		logic [3:0] rep;
		logic [PW-1:0] presc;
	} timer_s;

	timer_s cur_r;
	timer_s cur_nxt;

	// Next state of the counter
	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.step = 1'b0;
		cur_nxt.done = 1'b0;
		if (abort) begin
			cur_nxt.busy = 1'b0;
		end else if (start) begin
			cur_nxt.busy = 1'b1;
			cur_nxt.count = load;
			cur_nxt.rep_top = (repeat_cnt == 4'h0) ? 4'h0 : repeat_cnt - 4'h1;
			cur_nxt.rep = cur_nxt.rep_top;
			cur_nxt.presc = PRESC_TOP;
		end else if (cur_r.busy) begin
			if (cur_r.presc != '0) begin
				cur_nxt.presc = cur_r.presc - 1'b1;
			end else if (cur_r.rep != 4'h0) begin
				cur_nxt.rep = cur_r.rep - 4'h1;
				cur_nxt.presc = PRESC_TOP;
			end else begin
				cur_nxt.step = 1'b1;
				cur_nxt.presc = PRESC_TOP;
				cur_nxt.rep = cur_r.rep_top;
				if (cur_r.count == 8'h00) begin
					cur_nxt.busy = 1'b0; // Terminal count reached
					cur_nxt.done = 1'b1;
				end else begin
					cur_nxt.count = cur_r.count - 8'h01;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign busy = cur_r.busy;
	assign step = cur_r.step;
	assign done = cur_r.done;
endmodule : step_timer
